// file: src/phy_regs_pkg.sv
// Package for the PHY mode and status register bank.
// Assumes one 100 MHz clock and a 5-bit register index from the management engine.
package phy_regs_pkg;

  localparam int unsigned    CLOCK_HZ            = 100_000_000;
  localparam int unsigned    ENERGY_TIMEOUT_MS   = 256;
  localparam longint unsigned ENERGY_TIMEOUT_CYC =
    longint'(CLOCK_HZ) / 1000 * ENERGY_TIMEOUT_MS;

  localparam logic [4:0]  IDX_EXPANSION  = 5'h06;
  localparam logic [4:0]  IDX_MODE_CTL   = 5'h11;
  localparam logic [4:0]  IDX_SPECIAL    = 5'h12;
  localparam logic [4:0]  IDX_CROSSOVER  = 5'h1b;

  localparam int unsigned EXP_PD_FAULT   = 4;
  localparam int unsigned EXP_LP_NP      = 3;
  localparam int unsigned EXP_NP_ABLE    = 2;
  localparam int unsigned EXP_PAGE_RX    = 1;
  localparam int unsigned EXP_LP_AN      = 0;
  localparam int unsigned MC_EDPD        = 13;
  localparam int unsigned MC_ENERGY      = 1;
  localparam int unsigned XO_OVERRIDE    = 15;
  localparam int unsigned XO_AUTO        = 14;
  localparam int unsigned XO_STATE       = 13;
  localparam int unsigned XO_PLL_FORCE   = 10;
  localparam int unsigned XO_POLARITY    = 4;

  localparam logic [4:0]  ADDR_RESET     = 5'h01;
  localparam logic [2:0]  MODE_RESET     = 3'h7;
  localparam logic [15:0] ZERO16         = 16'h0000;

  typedef enum logic [2:0] {
    MODE_10_HALF   = 3'b000,
    MODE_10_FULL   = 3'b001,
    MODE_100_HALF  = 3'b010,
    MODE_100_FULL  = 3'b011,
    MODE_AN_100HD  = 3'b100,
    MODE_REPEATER  = 3'b101,
    MODE_RESERVED  = 3'b110,
    MODE_ALL       = 3'b111
  } op_mode_e;

  // Defaults offered to the basic control and advertisement registers
  typedef struct packed {
    logic       speed_100;
    logic       an_enable;
    logic       restart_an;
    logic       full_duplex;
    logic [3:0] advert;
    logic       crs_on_tx;
    logic       repeater;
    logic       follow_an;
  } mode_cfg_s;

  // Crossover and receive controls to the analog front end
  typedef struct packed {
    logic auto_crossover;
    logic swap_pairs;
    logic pll_ref_lock;
  } line_ctl_s;

endpackage

// file: src/energy_timer.sv
// Line energy watchdog: the status bit falls after a quiet timeout.
// Assumes energy_seen is synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module energy_timer #(
  parameter longint unsigned TIMEOUT = phy_regs_pkg::ENERGY_TIMEOUT_CYC
) (
  // Clock and hardware reset
  input  wire logic clock,
  input  wire logic hw_rst,
  // Line
  input  wire logic energy_seen,
  output logic      energy_present
);
  import phy_regs_pkg::*;

  logic [31:0] count_r;
  logic        present_r;

  wire at_limit = (count_r >= 32'(TIMEOUT - 1));

  // Soft reset is not wired in: the bit survives it
  always_ff @(posedge clock) begin
    if (hw_rst) begin
      count_r   <= 32'h0000_0000;
      present_r <= 1'b1;
    end else if (energy_seen) begin
      count_r   <= 32'h0000_0000;
      present_r <= 1'b1;
    end else if (at_limit) begin
      present_r <= 1'b0;
    end else begin
      count_r   <= count_r + 32'h0000_0001;
    end
  end

  assign energy_present = present_r;
endmodule
`default_nettype wire

// file: src/phy_mode_and_status_registers.sv
// Management register bank: expansion, mode control, special modes, crossover.
// Assumes a serial management engine presents decoded index, data and strobes.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Parallel detection fault sets expansion bit 4, held until read.
// - New page received sets expansion bit 1, latched until read.
// - Expansion bits 3, 2, 0 report next page and negotiation abilities.
// - Mode control bit 13 enables energy-detect power-down, reset 0.
// - Energy bit clears after 256 ms without energy, sets on energy.
// - Energy bit forced 1 by hardware reset, kept over soft reset.
// - Special modes bits 4:0 hold management address, reset 00001b.
// - Modes 000 and 001 give 10 Mb/s half and full, no negotiation.
// - Mode 010: 100 half, control 1000, carrier sense on tx and rx.
// - Mode 011: 100 full, control 1001, carrier sense on rx only.
// - Mode 100: negotiate 100 half only, control 1100, advert 0100.
// - Mode 101: repeater, negotiate 100 half only, carrier sense rx only.
// - Mode 111 advertises all; speed and duplex follow negotiation.
// - Crossover override bit 15 chooses strap pin or bits 14 and 13.
// - Override on: bit 14 enables auto crossover, else bit 13 manual.
// - Manual bit 13 zero keeps pairs normal, one swaps both.
// - Bit 10 forces receive PLL onto reference; 10 Mb/s reception lost.
// - Bit 4 reports 10 Mb/s receive polarity, 1 reversed.
// - Bits 3:0 of crossover register read undefined, writes ignored.
module phy_mode_and_status_registers #(
  parameter longint unsigned ENERGY_TIMEOUT = phy_regs_pkg::ENERGY_TIMEOUT_CYC,
  parameter logic [3:0]      LOW_NIBBLE     = 4'h0
) (
  // Clock and resets
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     soft_rst,
  // Management register access
  input  wire logic [4:0]               reg_index,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [15:0]              reg_wdata,
  output logic [15:0]                   reg_rdata,
  output logic                          reg_hit,
  // Status from negotiation and receive logic
  input  wire logic                     pd_fault_event,
  input  wire logic                     page_rx_event,
  input  wire logic                     lp_next_page_able,
  input  wire logic                     lp_an_able,
  input  wire logic                     energy_seen,
  input  wire logic                     rx_polarity_reversed,
  input  wire logic                     an_speed_100,
  input  wire logic                     an_full_duplex,
  // Strap
  input  wire logic                     auto_crossover_strap,
  // Settings to the datapath
  output logic [4:0]                    management_station_address,
  output phy_regs_pkg::op_mode_e        op_mode,
  output phy_regs_pkg::mode_cfg_s       mode_cfg,
  output logic                          energy_detect_powerdown_enable,
  output phy_regs_pkg::line_ctl_s       line_ctl
);
  import phy_regs_pkg::*;

  // Held registers
  logic       pd_fault_r;
  logic       page_rx_r;
  logic       edpd_r;
  logic [7:0] modes_hi_r;
  op_mode_e   mode_r;
  logic [4:0] addr_r;
  logic       xo_override_r;
  logic       xo_auto_r;
  logic       xo_state_r;
  logic       pll_force_r;
  logic       line_energy_present;

  // Address decode
  wire sel_exp  = (reg_index == IDX_EXPANSION);
  wire sel_mode = (reg_index == IDX_MODE_CTL);
  wire sel_spec = (reg_index == IDX_SPECIAL);
  wire sel_xo   = (reg_index == IDX_CROSSOVER);
  wire wr_mode  = reg_wr && sel_mode;
  wire wr_spec  = reg_wr && sel_spec;
  wire wr_xo    = reg_wr && sel_xo;
  wire rd_exp   = reg_rd && sel_exp;
  wire any_rst  = rst || soft_rst;

  energy_timer #(
    .TIMEOUT        (ENERGY_TIMEOUT)
  ) u_energy (
    .clock          (clock),
    .hw_rst         (rst),
    .energy_seen    (energy_seen),
    .energy_present (line_energy_present)
  );

  // Latch-high bits: a new event in the reading cycle wins over the clear
  always_ff @(posedge clock) begin
    if (any_rst) begin
      pd_fault_r <= 1'b0;
      page_rx_r  <= 1'b0;
    end else begin
      pd_fault_r <= pd_fault_event || (pd_fault_r && !rd_exp);
      page_rx_r  <= page_rx_event  || (page_rx_r  && !rd_exp);
    end
  end

  // Volatile control bits follow either reset
  always_ff @(posedge clock) begin
    if (any_rst) begin
      edpd_r        <= 1'b0;
      xo_override_r <= 1'b0;
      xo_auto_r     <= 1'b0;
      xo_state_r    <= 1'b0;
    end else begin
      if (wr_mode) begin
        edpd_r <= reg_wdata[MC_EDPD];
      end
      if (wr_xo) begin
        xo_override_r <= reg_wdata[XO_OVERRIDE];
        xo_auto_r     <= reg_wdata[XO_AUTO];
        xo_state_r    <= reg_wdata[XO_STATE];
      end
    end
  end

  // Fields kept over soft reset: only the hardware reset touches them
  always_ff @(posedge clock) begin
    if (rst) begin
      modes_hi_r  <= 8'h00;
      mode_r      <= op_mode_e'(MODE_RESET);
      addr_r      <= ADDR_RESET;
      pll_force_r <= 1'b0;
    end else begin
      if (wr_spec) begin
        modes_hi_r <= reg_wdata[15:8];
        mode_r     <= op_mode_e'(reg_wdata[7:5]);
        addr_r     <= reg_wdata[4:0];
      end
      if (wr_xo) begin
        pll_force_r <= reg_wdata[XO_PLL_FORCE];
      end
    end
  end

  // Read images
  wire [15:0] exp_img  = {11'h000, pd_fault_r, lp_next_page_able, 1'b0,
                          page_rx_r, lp_an_able};
  wire [15:0] mode_img = {2'b00, edpd_r, 11'h000, line_energy_present, 1'b0};
  wire [15:0] spec_img = {modes_hi_r, mode_r, addr_r};
  wire [15:0] xo_img   = {xo_override_r, xo_auto_r, xo_state_r, 2'b00,
                          pll_force_r, 5'h00, rx_polarity_reversed,
                          LOW_NIBBLE};

  assign reg_hit   = sel_exp || sel_mode || sel_spec || sel_xo;
  assign reg_rdata = sel_exp  ? exp_img  :
                     sel_mode ? mode_img :
                     sel_spec ? spec_img :
                     sel_xo   ? xo_img   : ZERO16;

  // Mode table
  mode_cfg_s cfg;
  always_comb begin
    cfg = '0;
    case (mode_r)
      MODE_10_HALF: begin
        cfg.crs_on_tx = 1'b1;
      end
      MODE_10_FULL: begin
        cfg.full_duplex = 1'b1;
      end
      MODE_100_HALF: begin
        cfg.speed_100 = 1'b1;
        cfg.crs_on_tx = 1'b1;
      end
      MODE_100_FULL: begin
        cfg.speed_100   = 1'b1;
        cfg.full_duplex = 1'b1;
      end
      MODE_AN_100HD: begin
        cfg.speed_100 = 1'b1;
        cfg.an_enable = 1'b1;
        cfg.advert    = 4'b0100;
        cfg.crs_on_tx = 1'b1;
      end
      MODE_REPEATER: begin
        cfg.speed_100 = 1'b1;
        cfg.an_enable = 1'b1;
        cfg.advert    = 4'b0100;
        cfg.repeater  = 1'b1;
      end
      MODE_ALL: begin
        cfg.an_enable   = 1'b1;
        cfg.advert      = 4'b1111;
        cfg.follow_an   = 1'b1;
        cfg.speed_100   = an_speed_100;
        cfg.full_duplex = an_full_duplex;
        cfg.crs_on_tx   = !an_full_duplex;
      end
      default: begin
        // Reserved mode: behave as plain 10 Mb/s half duplex
        cfg.crs_on_tx = 1'b1;
      end
    endcase
  end

  // Crossover selection; the override hands control from strap to register
  wire auto_x = xo_override_r ? xo_auto_r : auto_crossover_strap;
  wire swap_x = xo_override_r && !xo_auto_r && xo_state_r;

  assign management_station_address     = addr_r;
  assign op_mode                        = mode_r;
  assign mode_cfg                       = cfg;
  assign energy_detect_powerdown_enable = edpd_r;
  assign line_ctl.auto_crossover        = auto_x;
  assign line_ctl.swap_pairs            = swap_x;
  assign line_ctl.pll_ref_lock          = pll_force_r;
endmodule
`default_nettype wire

// file: verification/phy_regs_checker.sv
// Assertions on the PHY mode and status register bank.
// Sees only top-level ports; bound from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module phy_regs_checker
  import phy_regs_pkg::*;
(
  // Clock and resets
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    soft_rst,
  // Register access
  input wire logic [4:0]              reg_index,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_wdata,
  input wire logic [15:0]             reg_rdata,
  // Status and strap
  input wire logic                    pd_fault_event,
  input wire logic                    page_rx_event,
  input wire logic                    an_speed_100,
  input wire logic                    auto_crossover_strap,
  // Settings
  input wire logic [4:0]              management_station_address,
  input wire phy_regs_pkg::op_mode_e  op_mode,
  input wire phy_regs_pkg::mode_cfg_s mode_cfg,
  input wire logic                    energy_detect_powerdown_enable,
  input wire phy_regs_pkg::line_ctl_s line_ctl
);
  import phy_regs_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  addr_reset_a: assert property ($fell(rst) |-> management_station_address == ADDR_RESET)
    else $error("address not at reset value");
  cfg_write_a: assert property (reg_wr && reg_index == IDX_SPECIAL |=>
    {op_mode, management_station_address} == $past(reg_wdata[7:0])) else $error("mode write lost");
  edpd_write_a: assert property (reg_wr && reg_index == IDX_MODE_CTL && !soft_rst |=>
    energy_detect_powerdown_enable == $past(reg_wdata[13])) else $error("edpd write lost");
  soft_keep_a: assert property (soft_rst && !reg_wr |=> $stable(op_mode) &&
    $stable(management_station_address) && !energy_detect_powerdown_enable)
    else $error("soft reset effect wrong");
  fault_latch_a: assert property (pd_fault_event |=> reg_index != IDX_EXPANSION || reg_rdata[4])
    else $error("fault not latched");
  page_latch_a: assert property (page_rx_event |=> reg_index != IDX_EXPANSION || reg_rdata[1])
    else $error("page not latched");
  latch_hold_a: assert property (reg_index == IDX_EXPANSION && reg_rdata[1] && !reg_rd &&
    !soft_rst |=> reg_index != IDX_EXPANSION || reg_rdata[1]) else $error("latch dropped");
  half_100_a: assert property (op_mode == MODE_100_HALF |-> mode_cfg.speed_100 &&
    !mode_cfg.full_duplex && mode_cfg.crs_on_tx && !mode_cfg.an_enable) else $error("mode 010");
  full_100_a: assert property (op_mode == MODE_100_FULL |-> mode_cfg.speed_100 &&
    mode_cfg.full_duplex && !mode_cfg.crs_on_tx && !mode_cfg.an_enable) else $error("mode 011");
  neg_100_a: assert property (op_mode == MODE_AN_100HD |-> mode_cfg.an_enable &&
    mode_cfg.advert == 4'h4 && mode_cfg.crs_on_tx && !mode_cfg.repeater) else $error("mode 100");
  repeater_cfg_a: assert property (op_mode == MODE_REPEATER |-> mode_cfg.repeater &&
    mode_cfg.advert == 4'h4 && !mode_cfg.crs_on_tx && mode_cfg.an_enable) else $error("mode 101");
  all_modes_a: assert property (op_mode == MODE_ALL |-> mode_cfg.advert == 4'hf &&
    mode_cfg.speed_100 == an_speed_100) else $error("mode 111");
  strap_select_a: assert property (reg_index == IDX_CROSSOVER && !reg_rdata[15] |->
    line_ctl.auto_crossover == auto_crossover_strap) else $error("strap ignored");
  manual_swap_a: assert property (reg_index == IDX_CROSSOVER && reg_rdata[15] && !reg_rdata[14]
    |-> line_ctl.swap_pairs == reg_rdata[13] && !line_ctl.auto_crossover) else $error("swap wrong");
  pll_force_a: assert property (reg_index == IDX_CROSSOVER |->
    line_ctl.pll_ref_lock == reg_rdata[10]) else $error("pll force wrong");
  cover property (reg_rd && reg_index == IDX_EXPANSION && reg_rdata[1]);
  cover property (soft_rst);
  cover property (line_ctl.swap_pairs);
endmodule
`default_nettype wire

// file: verification/mgmt_station_model.sv
// Station management controller model issuing register strobes.
// Assumes wr and rd are called from one bench process only.
`timescale 1ns/1ns
`default_nettype none
module mgmt_station_model
  import phy_regs_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Register access
  output var logic [4:0]   reg_index,
  output var logic         reg_wr,
  output var logic         reg_rd,
  output var logic [15:0]  reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  import phy_regs_pkg::*;
  initial begin
    reg_index = 5'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    // Forbidden patterns are never sent, so the device is spared them
    if (i == IDX_SPECIAL && d[7:5] == MODE_RESERVED) return;
    if (i == IDX_CROSSOVER && d[15:13] == 3'h7) return;
    @(posedge clock);
    reg_index <= i;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
    // Released data must not look like a held copy
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [4:0] i, output logic [15:0] d);
    @(posedge clock);
    reg_index <= i;
    reg_rd <= 1'h1;
    @(posedge clock);
    d = reg_rdata;
    reg_rd <= 1'h0;
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the PHY mode and status register bank.
// Assumes the controller model drives all register strobes.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import phy_regs_pkg::*;
  logic clock, rst, soft_rst, pd_fault_event, page_rx_event, lp_next_page_able;
  logic lp_an_able, energy_seen, rx_polarity_reversed, an_speed_100, an_full_duplex;
  logic auto_crossover_strap, reg_wr, reg_rd, reg_hit, energy_detect_powerdown_enable;
  logic [4:0]  reg_index, management_station_address;
  logic [15:0] reg_wdata, reg_rdata;
  op_mode_e    op_mode;
  mode_cfg_s   mode_cfg;
  line_ctl_s   line_ctl;
  int          fail_count, samples_checked;
  logic [15:0] d;
  always #5 clock = ~clock;
  // Short quiet timeout keeps the energy scenario brief
  phy_mode_and_status_registers #(.ENERGY_TIMEOUT(16)) i_phy_mode_and_status_registers (
    .clock, .rst, .soft_rst, .reg_index, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_hit,
    .pd_fault_event, .page_rx_event, .lp_next_page_able, .lp_an_able, .energy_seen,
    .rx_polarity_reversed, .an_speed_100, .an_full_duplex, .auto_crossover_strap,
    .management_station_address, .op_mode, .mode_cfg, .energy_detect_powerdown_enable,
    .line_ctl);
  mgmt_station_model i_model (.clock, .reg_index, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_reset();
    lp_an_able <= 1'h1;
    lp_next_page_able <= 1'h1;
    i_model.rd(IDX_MODE_CTL, d);
    chk(d, 16'h0002);
    energy_seen <= 1'h1;
    i_model.rd(IDX_SPECIAL, d);
    chk(d, 16'h00e1);
    i_model.rd(IDX_EXPANSION, d);
    chk(d, 16'h0009);
    i_model.rd(5'h00, d);
    chk({d[15:1], reg_hit}, 16'h0000);
  endtask
  task automatic t_modes();
    logic [2:0] m;
    an_speed_100 <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      m = k[2:0];
      if (m == 3'h6) continue;
      i_model.wr(IDX_SPECIAL, {8'h00, m, 5'h03});
      chk(16'({op_mode, management_station_address}), 16'({m, 5'h03}));
      chk(16'(mode_cfg.speed_100), 16'(m[1] | m[2]));
      chk(16'(mode_cfg.full_duplex), 16'(m[0] & ~m[2]));
      chk(16'(mode_cfg.an_enable), 16'(m[2]));
      chk(16'(mode_cfg.advert), (m == 3'h7) ? 16'h000f : (m[2] ? 16'h0004 : 16'h0000));
      chk(16'(mode_cfg.repeater), 16'(m == 3'h5));
    end
  endtask
  task automatic t_latch();
    @(posedge clock);
    pd_fault_event <= 1'h1;
    page_rx_event <= 1'h1;
    @(posedge clock);
    pd_fault_event <= 1'h0;
    page_rx_event <= 1'h0;
    i_model.rd(IDX_EXPANSION, d);
    chk(d, 16'h001b);
    i_model.rd(IDX_EXPANSION, d);
    chk(d, 16'h0009);
  endtask
  task automatic t_soft();
    i_model.wr(IDX_MODE_CTL, 16'hffff);
    chk(16'(energy_detect_powerdown_enable), 16'h0001);
    i_model.rd(IDX_MODE_CTL, d);
    chk(d, 16'h2002);
    soft_rst <= 1'h1;
    @(posedge clock);
    soft_rst <= 1'h0;
    i_model.rd(IDX_MODE_CTL, d);
    chk(d, 16'h0002);
    i_model.rd(IDX_SPECIAL, d);
    chk(d, 16'h00e3);
  endtask
  task automatic t_energy();
    int n;
    energy_seen <= 1'h0;
    repeat (10) @(posedge clock);
    i_model.rd(IDX_MODE_CTL, d);
    chk(d, 16'h0002);
    n = 0;
    do begin
      i_model.rd(IDX_MODE_CTL, d);
      n++;
    end while (d[1] && n < 20);
    chk(d, 16'h0000);
    energy_seen <= 1'h1;
    i_model.rd(IDX_MODE_CTL, d);
    chk(d, 16'h0002);
  endtask
  task automatic t_xover();
    auto_crossover_strap <= 1'h1;
    rx_polarity_reversed <= 1'h1;
    i_model.wr(IDX_CROSSOVER, 16'h000f);
    chk(16'(line_ctl.auto_crossover), 16'h0001);
    i_model.rd(IDX_CROSSOVER, d);
    chk(d, 16'h0010);
    i_model.wr(IDX_CROSSOVER, 16'ha400);
    chk(16'(line_ctl), 16'h0003);
    i_model.wr(IDX_CROSSOVER, 16'hc000);
    chk(16'(line_ctl), 16'h0004);
    @(posedge clock);
    auto_crossover_strap <= 1'h0;
    i_model.wr(IDX_CROSSOVER, 16'h0000);
    chk(16'(line_ctl.auto_crossover), 16'h0000);
  endtask
  initial begin
    {clock, soft_rst, pd_fault_event, page_rx_event, lp_next_page_able} = 5'h00;
    {lp_an_able, energy_seen, rx_polarity_reversed, an_speed_100} = 4'h0;
    {an_full_duplex, auto_crossover_strap} = 2'h0;
    rst = 1'h1;
    fail_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    t_reset();
    t_modes();
    t_latch();
    t_soft();
    t_energy();
    t_xover();
    complete_run();
  end
endmodule
bind phy_mode_and_status_registers phy_regs_checker i_checker (
  .clock, .rst, .soft_rst, .reg_index, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .pd_fault_event, .page_rx_event, .an_speed_100, .auto_crossover_strap,
  .management_station_address, .op_mode, .mode_cfg, .energy_detect_powerdown_enable,
  .line_ctl);
`default_nettype wire
